// *** shared/cid_defs.vh ***
// constants of the instruction decoder core: bus map, field codes, reset values
// included by the core; holds definitions only
`ifndef CID_DEFS_VH
`define CID_DEFS_VH
// apb register byte offsets
`define CID_REG_CTRL     12'h000
`define CID_REG_CORE     12'h004
`define CID_REG_ACC      12'h008
`define CID_CTRL_RESET   1'b1
// special primary-plane locations
`define CID_F_STATUS     7'h03
`define CID_F_TABLE_DATA_POINTER_LO    7'h1D
`define CID_F_TABLE_DATA_POINTER_HI    7'h1E
// secondary-plane locations with side effects
`define CID_R_PWRDN      8'h03
`define CID_R_WDTCLR     8'h04
// status byte bit positions
`define CID_ST_C         0
`define CID_ST_DC        1
`define CID_ST_Z         2
`define CID_ST_PD        3
`define CID_ST_TO        4
`define CID_ST_RESET     5'h18
// instruction groups (bits 13:12)
`define CID_GRP_BYTE     2'b00
`define CID_GRP_LIT      2'b01
`define CID_GRP_CALL     2'b10
`define CID_GRP_JMP      2'b11
// byte-oriented operation codes (bits 11:8)
`define CID_OP_SPECIAL   4'h0
`define CID_OP_CLR       4'h1
`define CID_OP_SUB       4'h2
`define CID_OP_DEC       4'h3
`define CID_OP_IOR       4'h4
`define CID_OP_AND       4'h5
`define CID_OP_XOR       4'h6
`define CID_OP_ADD       4'h7
`define CID_OP_MOV       4'h8
`define CID_OP_COM       4'h9
`define CID_OP_INC       4'hA
`define CID_OP_DECSZ     4'hB
`define CID_OP_RRC       4'hC
`define CID_OP_RLC       4'hD
`define CID_OP_SWAP      4'hE
`define CID_OP_INCSZ     4'hF
// bit-oriented codes (bits 10:9, bit 11 low)
`define CID_BIT_CLR      2'b00
`define CID_BIT_SET      2'b01
`define CID_BIT_TSTC     2'b10
`define CID_BIT_TSTS     2'b11
// literal codes (bits 11:8, bit 11 high)
`define CID_LIT_RETURN_WITH_LITERAL_OP    4'h8
`define CID_LIT_MOVLW    4'h9
`define CID_LIT_IOR      4'hA
`define CID_LIT_AND      4'hB
`define CID_LIT_ADD      4'hC
`define CID_LIT_XOR      4'hD
`define CID_LIT_MOVE_ACC_TO_SECONDARY    4'hE
`define CID_LIT_MOVE_SECONDARY_TO_ACC    4'hF
// control words (low byte, bits 13:8 zero)
`define CID_W_RET        8'h40
`define CID_W_TABLE_READ_LOW_OP      8'h50
`define CID_W_TABLE_READ_HIGH_OP      8'h58
`define CID_W_INTERRUPT_RETURN_OP       8'h60
`define CID_W_CLRW       8'h40
// program counter and stack
`define CID_PC_RESET     12'h000
`define CID_SP_W         3
`endif

// *** rtl/cid_core.v ***
// instruction decoder and executor of a small 8-bit core, with apb control port
// assumes program memory answers the word at ROM_ADDR_O in the same cycle
//
// Overview of operation
// - each instruction is a 14-bit opcode-plus-operands word
// - destination bit 0 writes acc, 1 writes register
// - byte ops address primary plane 00h-7Fh
// - add and subtract update carry, digit carry, zero
// - rotates go through carry, only carry changes
// - decrement/increment skip on zero, flags untouched
// - one-cycle acc moves to/from secondary plane
// - bit clear/set use 3-bit bit, 6-bit address
// - bit tests skip next on clear or set
// - add literal updates carry, digit carry, zero
// - xor/or/and literal update only zero
// - call and jump load 12-bit address, two cycles
// - returns take two cycles; literal return loads acc
// - power-down stops core, updates time-out/power-down flags
// - watchdog clear resets counter, updates both flags
// - table reads fetch low/high word part, two cycles
// - table address comes from two pointer bytes
// - call pushes next address before jumping
`timescale 1ns/1ps
`include "cid_defs.vh"
module cid_core (
  input  wire        CLK_I,
  input  wire        RESET_I,
  input  wire [13:0] ROM_DATA_I,
  input  wire        WAKE_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [11:0] ROM_ADDR_O,
  output reg         SLEEP_O,
  output reg         WDT_CLR_O,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O
);
  localparam ST_EXEC  = 2'b00;
  localparam ST_BUBL  = 2'b01;
  localparam ST_TABL  = 2'b10;
  localparam ST_TABH  = 2'b11;

  reg [7:0]            fram [0:127];
  reg [7:0]            rram [0:255];
  reg [11:0]           stk  [0:(1<<`CID_SP_W)-1];
  reg [11:0]           pc_ff;
  reg [`CID_SP_W-1:0]  sp_ff;
  reg [7:0]            acc_ff;
  reg [4:0]            status_ff;
  reg [7:0]            table_data_pointer_lo_ff;
  reg [7:0]            table_data_pointer_hi_ff;
  reg [1:0]            state_ff;
  reg                  skip_ff;
  reg                  run_ff;

  reg [11:0]           nxt_pc;
  reg [`CID_SP_W-1:0]  nxt_sp;
  reg [7:0]            nxt_acc;
  reg [4:0]            nxt_status;
  reg [7:0]            nxt_table_data_pointer_lo;
  reg [7:0]            nxt_table_data_pointer_hi;
  reg [1:0]            nxt_state;
  reg                  nxt_skip;
  reg                  nxt_sleep;
  reg                  nxt_wdt;
  reg [11:0]           nxt_rom;
  reg                  f_we;
  reg [7:0]            f_wd;
  reg                  r_we;
  reg                  push;
  reg [8:0]            sum;
  reg [4:0]            nib;
  reg [7:0]            res;

  // instruction fields
  wire [13:0] ins    = ROM_DATA_I;
  wire [1:0]  grp    = ins[13:12];
  wire [3:0]  op     = ins[11:8];
  wire        dst    = ins[7];
  wire [6:0]  fadr   = ins[6:0];
  wire [6:0]  badr   = {1'b0, ins[5:0]};
  wire [2:0]  bnum   = ins[8:6];
  wire [7:0]  lit    = ins[7:0];
  wire [7:0]  radr   = ins[7:0];
  wire [6:0]  sel    = (grp == `CID_GRP_LIT) ? badr : fadr;
  wire [7:0]  fval   = fread(sel);
  wire [11:0] pc_inc = pc_ff + 12'h001;
  wire        active = run_ff & ~SLEEP_O;

  // primary-plane read, special locations mapped onto core state
  function [7:0] fread;
    input [6:0] a;
    begin
      if (a == `CID_F_STATUS)
        fread = {3'h0, status_ff};
      else if (a == `CID_F_TABLE_DATA_POINTER_LO)
        fread = table_data_pointer_lo_ff;
      else if (a == `CID_F_TABLE_DATA_POINTER_HI)
        fread = table_data_pointer_hi_ff;
      else
        fread = fram[a];
    end
  endfunction

  // decode and execute one instruction cycle
  always @* begin
    nxt_pc      = pc_ff;
    nxt_sp      = sp_ff;
    nxt_acc     = acc_ff;
    nxt_status  = status_ff;
    nxt_table_data_pointer_lo = table_data_pointer_lo_ff;
    nxt_table_data_pointer_hi = table_data_pointer_hi_ff;
    nxt_state   = state_ff;
    nxt_skip    = skip_ff;
    nxt_sleep   = SLEEP_O & ~WAKE_I;
    nxt_wdt     = 1'b0;
    nxt_rom     = ROM_ADDR_O;
    f_we        = 1'b0;
    f_wd        = 8'h00;
    r_we        = 1'b0;
    push        = 1'b0;
    sum         = 9'h000;
    nib         = 5'h00;
    res         = 8'h00;
    if (!active) begin
      nxt_rom = pc_ff;
    end else if (state_ff == ST_BUBL) begin
      nxt_state = ST_EXEC;
    end else if (state_ff == ST_TABL || state_ff == ST_TABH) begin
      nxt_acc   = (state_ff == ST_TABL) ? ins[7:0] : {2'b00, ins[13:8]};
      nxt_rom   = pc_ff;
      nxt_state = ST_EXEC;
    end else if (skip_ff) begin
      nxt_skip = 1'b0;
      nxt_pc   = pc_inc;
      nxt_rom  = pc_inc;
    end else begin
      nxt_pc  = pc_inc;
      nxt_rom = pc_inc;
      case (grp)
        `CID_GRP_BYTE: begin
          f_we = dst;
          case (op)
            `CID_OP_SPECIAL: begin
              f_we = 1'b0;
              if (dst) begin
                f_we = 1'b1;
                f_wd = acc_ff;
              end else if (lit == `CID_W_RET || lit == `CID_W_INTERRUPT_RETURN_OP) begin
                nxt_sp    = sp_ff - 1'b1;
                nxt_pc    = stk[sp_ff - 1'b1];
                nxt_rom   = stk[sp_ff - 1'b1];
                nxt_state = ST_BUBL;
              end else if (lit == `CID_W_TABLE_READ_LOW_OP || lit == `CID_W_TABLE_READ_HIGH_OP) begin
                nxt_rom   = {table_data_pointer_hi_ff[3:0], table_data_pointer_lo_ff};
                nxt_state = (lit == `CID_W_TABLE_READ_LOW_OP) ? ST_TABL : ST_TABH;
              end
            end
            `CID_OP_CLR: begin
              f_we = dst;
              if (!dst)
                nxt_acc = 8'h00;
              nxt_status[`CID_ST_Z] = 1'b1;
            end
            `CID_OP_ADD, `CID_OP_SUB: begin
              if (op == `CID_OP_ADD) begin
                sum = {1'b0, fval} + {1'b0, acc_ff};
                nib = {1'b0, fval[3:0]} + {1'b0, acc_ff[3:0]};
              end else begin
                sum = {1'b1, fval} - {1'b0, acc_ff};     // carry means no borrow
                nib = {1'b1, fval[3:0]} - {1'b0, acc_ff[3:0]};
              end
              res = sum[7:0];
              nxt_status[`CID_ST_C]  = sum[8];
              nxt_status[`CID_ST_DC] = nib[4];
              nxt_status[`CID_ST_Z]  = (res == 8'h00);
            end
            `CID_OP_RLC, `CID_OP_RRC: begin
              if (op == `CID_OP_RLC) begin
                res = {fval[6:0], status_ff[`CID_ST_C]};
                nxt_status[`CID_ST_C] = fval[7];
              end else begin
                res = {status_ff[`CID_ST_C], fval[7:1]};
                nxt_status[`CID_ST_C] = fval[0];
              end
            end
            `CID_OP_DECSZ, `CID_OP_INCSZ: begin
              res = (op == `CID_OP_DECSZ) ? fval - 8'h01 : fval + 8'h01;
              nxt_skip = (res == 8'h00);
            end
            `CID_OP_MOV: begin
              f_we = 1'b0;
              res  = fval;
              if (!dst)
                nxt_acc = fval;
              else
                nxt_status[`CID_ST_Z] = (fval == 8'h00);
            end
            `CID_OP_SWAP: begin
              res = {fval[3:0], fval[7:4]};
            end
            default: begin
              if (op == `CID_OP_DEC)
                res = fval - 8'h01;
              else if (op == `CID_OP_INC)
                res = fval + 8'h01;
              else if (op == `CID_OP_COM)
                res = ~fval;
              else if (op == `CID_OP_IOR)
                res = fval | acc_ff;
              else if (op == `CID_OP_AND)
                res = fval & acc_ff;
              else
                res = fval ^ acc_ff;
              nxt_status[`CID_ST_Z] = (res == 8'h00);
            end
          endcase
          if (op != `CID_OP_SPECIAL && op != `CID_OP_CLR && op != `CID_OP_MOV) begin
            f_wd = res;
            if (!dst)
              nxt_acc = res;
          end
        end
        `CID_GRP_LIT: begin
          if (!ins[11]) begin
            res = fval;
            case (ins[10:9])
              `CID_BIT_CLR: begin
                res[bnum] = 1'b0;
                f_we = 1'b1;
              end
              `CID_BIT_SET: begin
                res[bnum] = 1'b1;
                f_we = 1'b1;
              end
              `CID_BIT_TSTC:
                nxt_skip = ~fval[bnum];
              default:
                nxt_skip = fval[bnum];
            endcase
            f_wd = res;
          end else begin
            case (op)
              `CID_LIT_ADD: begin
                sum = {1'b0, acc_ff} + {1'b0, lit};
                nib = {1'b0, acc_ff[3:0]} + {1'b0, lit[3:0]};
                nxt_acc = sum[7:0];
                nxt_status[`CID_ST_C]  = sum[8];
                nxt_status[`CID_ST_DC] = nib[4];
                nxt_status[`CID_ST_Z]  = (sum[7:0] == 8'h00);
              end
              `CID_LIT_XOR, `CID_LIT_IOR, `CID_LIT_AND: begin
                if (op == `CID_LIT_XOR)
                  res = acc_ff ^ lit;
                else if (op == `CID_LIT_IOR)
                  res = acc_ff | lit;
                else
                  res = acc_ff & lit;
                nxt_acc = res;
                nxt_status[`CID_ST_Z] = (res == 8'h00);
              end
              `CID_LIT_MOVLW:
                nxt_acc = lit;
              `CID_LIT_RETURN_WITH_LITERAL_OP: begin
                nxt_acc   = lit;
                nxt_sp    = sp_ff - 1'b1;
                nxt_pc    = stk[sp_ff - 1'b1];
                nxt_rom   = stk[sp_ff - 1'b1];
                nxt_state = ST_BUBL;
              end
              `CID_LIT_MOVE_SECONDARY_TO_ACC:
                nxt_acc = rram[radr];
              default: begin
                r_we = 1'b1;
                if (radr == `CID_R_PWRDN) begin
                  nxt_sleep = 1'b1;
                  nxt_wdt   = 1'b1;
                  nxt_status[`CID_ST_TO] = 1'b1;
                  nxt_status[`CID_ST_PD] = 1'b0;
                end else if (radr == `CID_R_WDTCLR) begin
                  nxt_wdt = 1'b1;
                  nxt_status[`CID_ST_TO] = 1'b1;
                  nxt_status[`CID_ST_PD] = 1'b1;
                end
              end
            endcase
          end
        end
        default: begin
          push      = (grp == `CID_GRP_CALL);
          nxt_pc    = ins[11:0];
          nxt_rom   = ins[11:0];
          nxt_state = ST_BUBL;
          if (grp == `CID_GRP_CALL)
            nxt_sp = sp_ff + 1'b1;
        end
      endcase
      // writes aimed at special locations land in core state; a byte-op status write lands only if its flag update leaves status unchanged
      if (f_we && sel == `CID_F_STATUS && grp != `CID_GRP_BYTE)
        nxt_status = f_wd[4:0];
      else if (f_we && sel == `CID_F_STATUS && nxt_status == status_ff)
        nxt_status = f_wd[4:0];
      if (f_we && sel == `CID_F_TABLE_DATA_POINTER_LO)
        nxt_table_data_pointer_lo = f_wd;
      if (f_we && sel == `CID_F_TABLE_DATA_POINTER_HI)
        nxt_table_data_pointer_hi = f_wd;
    end
  end

  // core state registers
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pc_ff      <= `CID_PC_RESET;
      ROM_ADDR_O <= `CID_PC_RESET;
      sp_ff      <= {`CID_SP_W{1'b0}};
      acc_ff     <= 8'h00;
      status_ff  <= `CID_ST_RESET;
      table_data_pointer_lo_ff <= 8'h00;
      table_data_pointer_hi_ff <= 8'h00;
      state_ff   <= ST_EXEC;
      skip_ff    <= 1'b0;
      SLEEP_O    <= 1'b0;
      WDT_CLR_O  <= 1'b0;
    end else begin
      pc_ff      <= nxt_pc;
      ROM_ADDR_O <= nxt_rom;
      sp_ff      <= nxt_sp;
      acc_ff     <= nxt_acc;
      status_ff  <= nxt_status;
      table_data_pointer_lo_ff <= nxt_table_data_pointer_lo;
      table_data_pointer_hi_ff <= nxt_table_data_pointer_hi;
      state_ff   <= nxt_state;
      skip_ff    <= nxt_skip;
      SLEEP_O    <= nxt_sleep;
      WDT_CLR_O  <= nxt_wdt;
    end
  end

  // data planes and return stack, no reset
  always @(posedge CLK_I) begin
    if (f_we && sel != `CID_F_STATUS && sel != `CID_F_TABLE_DATA_POINTER_LO && sel != `CID_F_TABLE_DATA_POINTER_HI)
      fram[sel] <= f_wd;
    if (r_we)
      rram[radr] <= acc_ff;
    if (push)
      stk[sp_ff] <= pc_inc;
  end

  // apb slave, answers in the second access cycle
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      run_ff    <= `CID_CTRL_RESET;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h00000000;
    end else begin
      PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h00000000;
      if (PSEL_I && PENABLE_I && !PREADY_O) begin
        if (PADDR_I == `CID_REG_CTRL) begin
          if (PWRITE_I)
            run_ff <= PWDATA_I[0];
          else
            PRDATA_O <= {31'h00000000, run_ff};
        end else if (PADDR_I == `CID_REG_CORE) begin
          PRDATA_O <= {12'h000, 1'b0, skip_ff, state_ff, SLEEP_O, sp_ff, pc_ff};
        end else if (PADDR_I == `CID_REG_ACC) begin
          PRDATA_O <= {19'h00000, status_ff, acc_ff};
        end else begin
          PSLVERR_O <= 1'b1;
        end
      end
    end
  end
endmodule

// *** verification/cid_core_asserts.sv ***
// checker of the decoder core: handshake, reset and power-down relations at its ports
// bound to every cid_core instance; sees only that module's ports
`timescale 1ns/1ps
`include "cid_defs.vh"
module cid_core_asserts (
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic [13:0] ROM_DATA_I,
  input wire logic        WAKE_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [11:0] ROM_ADDR_O,
  input wire logic        SLEEP_O,
  input wire logic        WDT_CLR_O,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O
);
  localparam logic [13:0] W_SLEEP = 14'h1E03;
  localparam logic [13:0] W_WDT   = 14'h1E04;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  // apb steps: request taken, then a one-cycle answer
  sequence apb_taken;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence
  sequence apb_answer;
    PREADY_O ##1 !PREADY_O;
  endsequence
  sequence sleep_enter;
    !SLEEP_O ##1 SLEEP_O;
  endsequence
  // outputs quiet and fetch at zero right after reset
  a_reset_quiet: assert property ($fell(RESET_I) |-> ROM_ADDR_O == `CID_PC_RESET
    && !SLEEP_O && !WDT_CLR_O && !PREADY_O && !PSLVERR_O)
    else $error("outputs not at reset values after release");
  a_apb_answer: assert property (apb_taken |=> apb_answer)
    else $error("apb answer not a single cycle one clock after request");
  a_ready_cause: assert property (PREADY_O |-> $past(PSEL_I) && $past(PENABLE_I))
    else $error("ready without a request");
  a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data not zero outside answer");
  a_err_map: assert property (PREADY_O |-> PSLVERR_O == !($past(PADDR_I) inside
    {`CID_REG_CTRL, `CID_REG_CORE, `CID_REG_ACC}))
    else $error("error flag does not match address map");
  a_err_quiet: assert property (!PREADY_O |-> !PSLVERR_O)
    else $error("error flag outside answer");
  // watchdog pulse only from a clear or power-down word
  a_wdt_cause: assert property (WDT_CLR_O |-> !$past(SLEEP_O)
    && ($past(ROM_DATA_I) == W_SLEEP || $past(ROM_DATA_I) == W_WDT))
    else $error("watchdog pulse without its instruction");
  a_sleep_entry: assert property (sleep_enter |-> $past(ROM_DATA_I) == W_SLEEP && WDT_CLR_O)
    else $error("power-down entered without its instruction");
  a_sleep_hold: assert property (SLEEP_O |=> $stable(ROM_ADDR_O))
    else $error("fetch address moved while powered down");
  a_wake_exit: assert property (SLEEP_O && WAKE_I |=> !SLEEP_O)
    else $error("wake request did not end power-down");
endmodule
bind cid_core cid_core_asserts chk (.CLK_I(CLK_I), .RESET_I(RESET_I), .ROM_DATA_I(ROM_DATA_I),
  .WAKE_I(WAKE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .ROM_ADDR_O(ROM_ADDR_O), .SLEEP_O(SLEEP_O),
  .WDT_CLR_O(WDT_CLR_O), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O));

// *** verification/cid_prog_mem.sv ***
// program memory model: array of instruction words answering the addressed word at once
// assumes the bench fills the array while the core is held in reset
`timescale 1ns/1ps
module cid_prog_mem (
  input  wire logic [11:0] addr_i,
  output logic      [13:0] data_o
);
  logic [13:0] mem [0:4095];
  // same-cycle read, also serves table lookups
  assign data_o = mem[addr_i];
endmodule

// *** verification/cid_core_bench.sv ***
// bench of the decoder core: programs run from the memory model, results read over apb
// assumes the core, its checker and the memory model are compiled alongside
`timescale 1ns/1ps
module cid_core_bench;
  logic        clk, rst, wake, psel, pen, pwr, sleep, wdt, pready, perr, e;
  logic [11:0] paddr, raddr;
  logic [13:0] rdat;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail, n_checks, n_wdt;
  cid_prog_mem rom (.addr_i(raddr), .data_o(rdat));
  cid_core uut (.CLK_I(clk), .RESET_I(rst), .ROM_DATA_I(rdat), .WAKE_I(wake), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .ROM_ADDR_O(raddr),
    .SLEEP_O(sleep), .WDT_CLR_O(wdt), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count watchdog pulses
  always @(posedge clk) begin
    if (wdt === 1'b1) n_wdt++;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task ended(input string s);
    $display("%s ended, mismatches so far %0d", s, n_fail);
  endtask
  // one apb transfer: setup, access held until ready, then release
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      check({31'h0, pready}, 32'h1);
      print_verdict;
    end
  endtask
  // hold reset and load a program at address zero, rest of memory no-ops
  task boot(input logic [13:0] p[$]);
    @(posedge clk);
    rst <= 1'b1;
    n_wdt = 0;
    @(negedge clk);
    for (int i = 0; i < 4096; i++) rom.mem[i] = 14'h0000;
    foreach (p[i]) rom.mem[i] = p[i];
    repeat (4) @(posedge clk);
  endtask
  // release, let the program reach its final loop, freeze, compare acc and status
  task done(input logic [31:0] exp);
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, exp);
  endtask
  task t_apb;
    boot('{14'h3000});
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h1800);
    check({31'h0, e}, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check({rd[30:0], e}, 32'h1);
    apb(1'b1, 12'h010, 32'h5);
    check({31'h0, e}, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    ended("register map");
  endtask
  task t_literals;
    logic [13:0] a [5];
    logic [13:0] o [5];
    logic [31:0] x [5];
    a = '{14'h199A, 14'h1901, 14'h195A, 14'h199A, 14'h19A3};
    o = '{14'h1C7F, 14'h1CFF, 14'h1D5A, 14'h1A35, 14'h1B5F};
    x = '{32'h1B19, 32'h1F00, 32'h1C00, 32'h18BF, 32'h1803};
    for (int i = 0; i < 5; i++) begin
      boot('{a[i], o[i], 14'h3002});
      done(x[i]);
    end
    ended("literals");
  endtask
  task t_byte;
    boot('{14'h1917, 14'h00FF, 14'h19C2, 14'h07FF, 14'h027F, 14'h3005});
    done(32'h1B17);
    boot('{14'h1981, 14'h00A0, 14'h0D20, 14'h0CA0, 14'h0820, 14'h3005});
    done(32'h19C0);
    ended("byte ops");
  endtask
  // or, complement, and, swap, xor, dec, inc, clear, test-zero, both bit-test skips
  task t_logic;
    boot('{14'h1913, 14'h00A4, 14'h1991, 14'h0424, 14'h09A4, 14'h05A4,
      14'h0EA4, 14'h06A4, 14'h03A4, 14'h0A24, 14'h01A5, 14'h1683,
      14'h0140, 14'h08A4, 14'h1483, 14'h0140, 14'h3010});
    done(32'h189B);
    ended("logic and clear ops");
  endtask
  task t_skips;
    boot('{14'h1901, 14'h00A1, 14'h0BA1, 14'h3040, 14'h0F21, 14'h1621, 14'h1911, 14'h1421,
      14'h1C40, 14'h3009});
    rom.mem[12'h040] = 14'h19EE;
    rom.mem[12'h041] = 14'h3041;
    done(32'h1811);
    ended("skips");
  endtask
  task t_bits;
    boot('{14'h19C7, 14'h00A2, 14'h11E2, 14'h12E2, 14'h0822, 14'h1E80, 14'h1900, 14'h1F80,
      14'h3008});
    done(32'h184F);
    ended("bits and secondary plane");
  endtask
  task t_calls;
    boot('{14'h2020, 14'h1C01, 14'h2010, 14'h2030, 14'h3004});
    rom.mem[12'h010] = 14'h1C10;
    rom.mem[12'h011] = 14'h0060;
    rom.mem[12'h020] = 14'h1855;
    rom.mem[12'h030] = 14'h0040;
    done(32'h1866);
    apb(1'b0, 12'h004, 32'h0);
    check({17'h0, rd[14:0]}, 32'h4);
    ended("calls");
  endtask
  task t_table;
    boot('{14'h1980, 14'h009D, 14'h1912, 14'h009E, 14'h0058, 14'h00A3, 14'h0050, 14'h0723,
      14'h3008});
    rom.mem[12'h280] = 14'h2A5C;
    done(32'h1A86);
    ended("table read");
  endtask
  task t_sleep;
    boot('{14'h1E04, 14'h1E03, 14'h1933, 14'h3003});
    rst <= 1'b0;
    for (int k = 0; k < 20 && sleep !== 1'b1; k++) @(posedge clk);
    if (sleep !== 1'b1) begin
      check({31'h0, sleep}, 32'h1);
      print_verdict;
    end
    repeat (3) @(posedge clk);
    check({20'h0, raddr}, 32'h2);
    check(n_wdt, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h1000);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    done(32'h1033);
    ended("power down");
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    wake = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    n_checks = 0;
    n_wdt = 0;
    repeat (4) @(posedge clk);
    t_apb;
    t_literals;
    t_byte;
    t_logic;
    t_skips;
    t_bits;
    t_calls;
    t_table;
    t_sleep;
    print_verdict;
  end
endmodule
